// [shared/csie_pkg.sv]
// How it works
// RQ1: memory card battery line change sets flags 1,0
// RQ2: memory card ready change sets flag 2
// RQ3: I/O card status assertion sets flag 0
// RQ4: I/O card irq shows at config 91h bit0
// RQ5: CardBus status assertion sets socket event bit0
// RQ6: CardBus irq shares config 91h bit0
// RQ7: any detect change sets socket bits 2,1
// RQ8: power-up done sets bit 3 by type
// RQ9: memory cards never raise functional interrupts
// RQ10: status sources maskable, functional never masked
// RQ11: status and functional routed to separate outputs
// RQ12: write-one clears legacy flag in that mode
// RQ13: global control bit2 selects clear scheme, read default
// RQ14: write one clears socket event flag
// RQ15: software avoids using both register sets together
// RQ16: shared pins read per inserted card type
// RQ17: status interrupt level or edge per mode bit
// RQ18: status interrupt while any enabled flag pending; code does so only with gctrl bit1 clear
`default_nettype none
package csie_pkg;
	// inserted card type
	typedef enum logic [1:0] {
		CSIE_CARD_NONE = 2'b00,
		CSIE_CARD_MEM  = 2'b01,
		CSIE_CARD_IO   = 2'b10,
		CSIE_CARD_CB   = 2'b11
	} csie_card_t;

	// register space addressed by a request
	typedef enum logic [1:0] {
		CSIE_SPACE_LEGACY = 2'b00,
		CSIE_SPACE_CONFIG = 2'b01,
		CSIE_SPACE_SOCKET = 2'b10,
		CSIE_SPACE_NONE   = 2'b11
	} csie_space_t;

	// socket terminals, high means asserted or high level
	typedef struct packed {
		logic battery_detect_one;   // also status line on I/O and CardBus
		logic battery_detect_two;
		logic shared_ready_irq;     // ready / io irq / cb irq
		logic card_detect_one;
		logic card_detect_two;
	} csie_pins_t;

	// register request
	typedef struct packed {
		logic        wr;
		logic        rd;
		csie_space_t space;
		logic [7:0]  addr;
		logic [31:0] wdata;
	} csie_req_t;

	localparam int CSIE_NUM_PINS = 5;
	localparam int CSIE_PIN_BATTERY_DETECT_ONE = 4;
	localparam int CSIE_PIN_BATTERY_DETECT_TWO = 3;
	localparam int CSIE_PIN_RDY  = 2;
	localparam int CSIE_PIN_CD1  = 1;
	localparam int CSIE_PIN_CD2  = 0;

	// legacy socket register offsets
	localparam logic [7:0] CSIE_OFS_FLAGS  = 8'h04;
	localparam logic [7:0] CSIE_OFS_MASKS  = 8'h05;
	localparam logic [7:0] CSIE_OFS_GCTRL  = 8'h1E;
	// config space offsets
	localparam logic [7:0] CSIE_OFS_FUNC   = 8'h91;
	localparam logic [7:0] CSIE_OFS_ROUTE  = 8'hC0;
	// socket space offsets
	localparam logic [7:0] CSIE_OFS_SEVENT = 8'h00;
	localparam logic [7:0] CSIE_OFS_SMASK  = 8'h04;

	// flag bit positions
	localparam int CSIE_BIT_BATTERY_DETECT_ONE  = 0;
	localparam int CSIE_BIT_BATTERY_DETECT_TWO  = 1;
	localparam int CSIE_BIT_RDY   = 2;
	localparam int CSIE_BIT_PWR   = 3;
	localparam int CSIE_BIT_CSTS  = 0;
	localparam int CSIE_BIT_CD1   = 1;
	localparam int CSIE_BIT_CD2   = 2;
	localparam int CSIE_BIT_FUNC  = 0;
	localparam int CSIE_BIT_IFCM  = 2;
	localparam int CSIE_BIT_CSCM  = 1;
	localparam int CSIE_NUM_SRC   = 4;

	// routing register fields
	localparam int CSIE_ROUTE_W      = 2;
	localparam int CSIE_ROUTE_CSC_LO = 0;
	localparam int CSIE_ROUTE_FN_LO  = 4;

	// reset values
	localparam logic [7:0]  CSIE_RST_BYTE  = 8'h00;
	localparam logic [31:0] CSIE_RST_WORD  = 32'h0000_0000;
	localparam logic [1:0]  CSIE_RST_RCSC  = 2'h0;
	localparam logic [1:0]  CSIE_RST_RFN   = 2'h1;
endpackage
`default_nettype wire

// [rtl/csie_edge.sv]
`timescale 1ns/100ps
`default_nettype none
// three-stage synchroniser with agreed-level change detect
module csie_edge (
	input  wire logic clock_in,
	input  wire logic sys_rst_in,
	input  wire logic pin_in,
	output logic      level_out,
	output logic      change_out,
	output logic      rise_out
);
	logic sync_a;
	logic sync_b;
	logic sync_c;
	logic stable;
	logic next_stable;
	logic agree;

	// a change counts once the second and third stages agree
	always_comb begin
		agree       = (sync_b == sync_c);
		next_stable = agree ? sync_c : stable;
		change_out  = agree && (sync_c != stable);
		rise_out    = change_out && sync_c;
		level_out   = stable;
	end

	// sync_a feeds only sync_b
	always_ff @(posedge clock_in) begin
		if (sys_rst_in) begin
			sync_a <= 1'b0;
			sync_b <= 1'b0;
			sync_c <= 1'b0;
			stable <= 1'b0;
		end else begin
			sync_a <= pin_in;
			sync_b <= sync_a;
			sync_c <= sync_b;
			stable <= next_stable;
		end
	end
endmodule // csie_edge
`default_nettype wire

// [rtl/csie_events.sv]
`timescale 1ns/100ps
`default_nettype none
// card socket event flags, masks, clear schemes and routing
module csie_events #(
	parameter int NUM_IRQ = 4
) (
	input  wire logic                   clock_in,
	input  wire logic                   sys_rst_in,
	input  wire csie_pkg::csie_card_t   card_type_in,
	input  wire csie_pkg::csie_pins_t   pins_in,
	input  wire logic                   power_done_in,
	input  wire csie_pkg::csie_req_t    req_in,
	output logic [31:0]                 rdata_out,
	output logic [NUM_IRQ-1:0]          sys_irq_out,
	output logic                        status_irq_out,
	output logic                        func_irq_out
);
	logic [csie_pkg::CSIE_NUM_PINS-1:0] pin_vec;
	logic [csie_pkg::CSIE_NUM_PINS-1:0] lvl;
	logic [csie_pkg::CSIE_NUM_PINS-1:0] chg;
	logic [csie_pkg::CSIE_NUM_PINS-1:0] rise;

	logic [7:0]  leg_flags;
	logic [7:0]  leg_masks;
	logic [7:0]  gctrl;
	logic [7:0]  route;
	logic [31:0] sock_flags;
	logic [31:0] sock_masks;
	logic [31:0] rdata;
	logic [csie_pkg::CSIE_NUM_SRC-1:0] en_q;
	logic        status_irq;
	logic        func_irq;
	logic [NUM_IRQ-1:0] sys_irq;

	logic [7:0]  next_leg_flags;
	logic [7:0]  next_leg_masks;
	logic [7:0]  next_gctrl;
	logic [7:0]  next_route;
	logic [31:0] next_sock_flags;
	logic [31:0] next_sock_masks;
	logic [31:0] next_rdata;
	logic [csie_pkg::CSIE_NUM_SRC-1:0] next_en_q;
	logic        next_status_irq;
	logic        next_func_irq;
	logic [NUM_IRQ-1:0] next_sys_irq;

	assign pin_vec = pins_in;

	// one synchroniser per socket terminal
	genvar gi;
	generate
		for (gi = 0; gi < csie_pkg::CSIE_NUM_PINS; gi++) begin : g_pin
			csie_edge u_edge (
				.clock_in   (clock_in),
				.sys_rst_in (sys_rst_in),
				.pin_in     (pin_vec[gi]),
				.level_out  (lvl[gi]),
				.change_out (chg[gi]),
				.rise_out   (rise[gi])
			);
		end
	endgenerate

	// card type decode of shared terminals
	logic is_mem;
	logic is_io;
	logic is_cb;
	logic wr_flags;
	logic rd_flags;
	logic wr_masks;
	logic wr_gctrl;
	logic wr_route;
	logic wr_sevent;
	logic wr_smask;
	logic [7:0]  leg_set;
	logic [7:0]  leg_clr;
	logic [31:0] sock_set;
	logic [31:0] sock_clr;
	logic [csie_pkg::CSIE_NUM_SRC-1:0] enabled;
	logic        csc_pend;
	logic        func_lvl;
	logic [csie_pkg::CSIE_ROUTE_W-1:0] rt_csc;
	logic [csie_pkg::CSIE_ROUTE_W-1:0] rt_fn;

	// request decode
	always_comb begin
		is_mem    = (card_type_in == csie_pkg::CSIE_CARD_MEM);  // RQ16
		is_io     = (card_type_in == csie_pkg::CSIE_CARD_IO);   // RQ16
		is_cb     = (card_type_in == csie_pkg::CSIE_CARD_CB);   // RQ16
		wr_flags  = req_in.wr && req_in.space == csie_pkg::CSIE_SPACE_LEGACY
			&& req_in.addr == csie_pkg::CSIE_OFS_FLAGS;
		rd_flags  = req_in.rd && req_in.space == csie_pkg::CSIE_SPACE_LEGACY
			&& req_in.addr == csie_pkg::CSIE_OFS_FLAGS;
		wr_masks  = req_in.wr && req_in.space == csie_pkg::CSIE_SPACE_LEGACY
			&& req_in.addr == csie_pkg::CSIE_OFS_MASKS;
		wr_gctrl  = req_in.wr && req_in.space == csie_pkg::CSIE_SPACE_LEGACY
			&& req_in.addr == csie_pkg::CSIE_OFS_GCTRL;
		wr_route  = req_in.wr && req_in.space == csie_pkg::CSIE_SPACE_CONFIG
			&& req_in.addr == csie_pkg::CSIE_OFS_ROUTE;
		wr_sevent = req_in.wr && req_in.space == csie_pkg::CSIE_SPACE_SOCKET
			&& req_in.addr == csie_pkg::CSIE_OFS_SEVENT;
		wr_smask  = req_in.wr && req_in.space == csie_pkg::CSIE_SPACE_SOCKET
			&& req_in.addr == csie_pkg::CSIE_OFS_SMASK;
	end

	// event sources per card type
	always_comb begin
		leg_set  = csie_pkg::CSIE_RST_BYTE;
		sock_set = csie_pkg::CSIE_RST_WORD;
		leg_set[csie_pkg::CSIE_BIT_BATTERY_DETECT_ONE] = (is_mem && chg[csie_pkg::CSIE_PIN_BATTERY_DETECT_ONE])  // RQ1
			|| (is_io && rise[csie_pkg::CSIE_PIN_BATTERY_DETECT_ONE]);                          // RQ3
		leg_set[csie_pkg::CSIE_BIT_BATTERY_DETECT_TWO] = is_mem && chg[csie_pkg::CSIE_PIN_BATTERY_DETECT_TWO];   // RQ1
		leg_set[csie_pkg::CSIE_BIT_RDY]  = is_mem && chg[csie_pkg::CSIE_PIN_RDY];    // RQ2
		leg_set[csie_pkg::CSIE_BIT_PWR]  = power_done_in && (is_mem || is_io);       // RQ8
		sock_set[csie_pkg::CSIE_BIT_CSTS] = is_cb && rise[csie_pkg::CSIE_PIN_BATTERY_DETECT_ONE];  // RQ5
		sock_set[csie_pkg::CSIE_BIT_CD1]  = chg[csie_pkg::CSIE_PIN_CD1];             // RQ7
		sock_set[csie_pkg::CSIE_BIT_CD2]  = chg[csie_pkg::CSIE_PIN_CD2];             // RQ7
		sock_set[csie_pkg::CSIE_BIT_PWR]  = power_done_in && is_cb;                  // RQ8
		// functional request only for I/O and CardBus, never masked
		func_lvl = (is_io || is_cb) && lvl[csie_pkg::CSIE_PIN_RDY];  // RQ4 RQ6 RQ9 RQ10
	end

	// flag clearing, set wins over clear
	always_comb begin
		leg_clr = csie_pkg::CSIE_RST_BYTE;
		if (gctrl[csie_pkg::CSIE_BIT_IFCM]) begin
			if (wr_flags) begin
				leg_clr = req_in.wdata[7:0];  // RQ12
			end
		end else if (rd_flags) begin
			leg_clr = 8'hFF;  // RQ13
		end
		sock_clr        = wr_sevent ? req_in.wdata : csie_pkg::CSIE_RST_WORD;  // RQ14
		next_leg_flags  = (leg_flags & ~leg_clr) | leg_set;
		next_sock_flags = (sock_flags & ~sock_clr) | sock_set;
		next_leg_masks  = wr_masks ? req_in.wdata[7:0] : leg_masks;
		next_gctrl      = wr_gctrl ? req_in.wdata[7:0] : gctrl;  // RQ13
		next_route      = wr_route ? req_in.wdata[7:0] : route;
		next_sock_masks = wr_smask ? req_in.wdata : sock_masks;
	end

	// status interrupt and routing
	always_comb begin
		enabled = (leg_flags[csie_pkg::CSIE_NUM_SRC-1:0] & leg_masks[csie_pkg::CSIE_NUM_SRC-1:0])
			| (sock_flags[csie_pkg::CSIE_NUM_SRC-1:0] & sock_masks[csie_pkg::CSIE_NUM_SRC-1:0]);  // RQ10
		csc_pend        = |enabled;  // RQ18
		next_en_q       = enabled;
		if (gctrl[csie_pkg::CSIE_BIT_CSCM]) begin
			next_status_irq = |(enabled & ~en_q);  // RQ17
		end else begin
			next_status_irq = csc_pend;  // RQ17 RQ18
		end
		next_func_irq = func_lvl;
		rt_csc = route[csie_pkg::CSIE_ROUTE_CSC_LO +: csie_pkg::CSIE_ROUTE_W];
		rt_fn  = route[csie_pkg::CSIE_ROUTE_FN_LO +: csie_pkg::CSIE_ROUTE_W];
		next_sys_irq = '0;
		for (int i = 0; i < NUM_IRQ; i++) begin
			next_sys_irq[i] = (next_status_irq && rt_csc == i[csie_pkg::CSIE_ROUTE_W-1:0])
				|| (next_func_irq && rt_fn == i[csie_pkg::CSIE_ROUTE_W-1:0]);  // RQ11
		end
	end

	// read data, unmapped reads return zero
	always_comb begin
		next_rdata = csie_pkg::CSIE_RST_WORD;
		if (req_in.rd) begin
			case (req_in.space)
				csie_pkg::CSIE_SPACE_LEGACY: begin
					if (req_in.addr == csie_pkg::CSIE_OFS_FLAGS) begin
						next_rdata[7:0] = leg_flags;
					end else if (req_in.addr == csie_pkg::CSIE_OFS_MASKS) begin
						next_rdata[7:0] = leg_masks;
					end else if (req_in.addr == csie_pkg::CSIE_OFS_GCTRL) begin
						next_rdata[7:0] = gctrl;
					end
				end
				csie_pkg::CSIE_SPACE_CONFIG: begin
					if (req_in.addr == csie_pkg::CSIE_OFS_FUNC) begin
						next_rdata[csie_pkg::CSIE_BIT_FUNC] = func_irq;  // RQ4 RQ6
					end else if (req_in.addr == csie_pkg::CSIE_OFS_ROUTE) begin
						next_rdata[7:0] = route;
					end
				end
				csie_pkg::CSIE_SPACE_SOCKET: begin
					if (req_in.addr == csie_pkg::CSIE_OFS_SEVENT) begin
						next_rdata = sock_flags;
					end else if (req_in.addr == csie_pkg::CSIE_OFS_SMASK) begin
						next_rdata = sock_masks;
					end
				end
				default: begin
					next_rdata = csie_pkg::CSIE_RST_WORD;
				end
			endcase
		end
	end

	// state registers
	always_ff @(posedge clock_in) begin
		if (sys_rst_in) begin
			leg_flags  <= csie_pkg::CSIE_RST_BYTE;
			leg_masks  <= csie_pkg::CSIE_RST_BYTE;
			gctrl      <= csie_pkg::CSIE_RST_BYTE;
			route      <= {2'h0, csie_pkg::CSIE_RST_RFN, 2'h0, csie_pkg::CSIE_RST_RCSC};
			sock_flags <= csie_pkg::CSIE_RST_WORD;
			sock_masks <= csie_pkg::CSIE_RST_WORD;
			rdata      <= csie_pkg::CSIE_RST_WORD;
			en_q       <= '0;
			status_irq <= 1'b0;
			func_irq   <= 1'b0;
			sys_irq    <= '0;
		end else begin
			leg_flags  <= next_leg_flags;
			leg_masks  <= next_leg_masks;
			gctrl      <= next_gctrl;
			route      <= next_route;
			sock_flags <= next_sock_flags;
			sock_masks <= next_sock_masks;
			rdata      <= next_rdata;
			en_q       <= next_en_q;
			status_irq <= next_status_irq;
			func_irq   <= next_func_irq;
			sys_irq    <= next_sys_irq;
		end
	end

	assign rdata_out      = rdata;
	assign sys_irq_out    = sys_irq;
	assign status_irq_out = status_irq;
	assign func_irq_out   = func_irq;
endmodule // csie_events
`default_nettype wire

// [testbench/csie_events_properties.sv]
`timescale 1ns/100ps
`default_nettype none
// port checks of the socket event block
module csie_events_chk #(
	parameter int NUM_IRQ = 4
) (
	input wire logic                 clock_in,
	input wire logic                 sys_rst_in,
	input wire csie_pkg::csie_card_t card_type_in,
	input wire csie_pkg::csie_pins_t pins_in,
	input wire logic                 power_done_in,
	input wire csie_pkg::csie_req_t  req_in,
	input wire logic [NUM_IRQ-1:0]   sys_irq_out,
	input wire logic                 status_irq_out,
	input wire logic                 func_irq_out
);
	logic [7:0]         gc;
	logic [7:0]         lm;
	logic [7:0]         sm;
	logic [7:0]         rt;
	logic [NUM_IRQ-1:0] exp_irq;
	logic               mem;
	default clocking @(posedge clock_in);
	endclocking
	default disable iff (sys_rst_in);
	// shadow control registers from host writes
	always_ff @(posedge clock_in) begin
		if (sys_rst_in) begin
			gc <= 8'h00;
			lm <= 8'h00;
			sm <= 8'h00;
			rt <= 8'h10;
		end else begin
			case ({req_in.wr, req_in.space, req_in.addr})
				11'h41E: gc <= req_in.wdata[7:0];
				11'h405: lm <= req_in.wdata[7:0];
				11'h604: sm <= req_in.wdata[7:0];
				11'h5C0: rt <= req_in.wdata[7:0];
				default: ;
			endcase
		end
	end
	// expected routed lines
	assign mem = card_type_in == csie_pkg::CSIE_CARD_MEM;
	assign exp_irq = (NUM_IRQ'(status_irq_out) << rt[1:0]) | (NUM_IRQ'(func_irq_out) << rt[5:4]);
	// status interrupt after a pin event or an internal event
	sequence s_raise;
		##[3:6] status_irq_out;
	endsequence
	sequence s_soon;
		##[1:3] status_irq_out;
	endsequence
	property p_func_on;
		(card_type_in[1] && pins_in.shared_ready_irq) [*8] |-> func_irq_out;
	endproperty
	a_func_on: assert property (p_func_on) else $error("functional irq missing");
	property p_func_mem;
		mem [*6] |-> !func_irq_out;
	endproperty
	a_func_mem: assert property (p_func_mem) else $error("functional irq on memory card");
	property p_route;
		$stable(rt) |-> sys_irq_out == exp_irq;
	endproperty
	a_route: assert property (p_route) else $error("system irq routing wrong");
	property p_edge;
		gc[1] && $stable(gc) && status_irq_out |=> !status_irq_out;
	endproperty
	a_edge: assert property (p_edge) else $error("edge mode pulse too long");
	property p_masked;
		(lm[3:0] == 4'h0 && sm[3:0] == 4'h0) [*6] |-> !status_irq_out;
	endproperty
	a_masked: assert property (p_masked) else $error("status irq while all masked");
	property p_pwr;
		power_done_in && !gc[1] && card_type_in[0] && (card_type_in[1] ? sm[3] : lm[3]) |-> s_soon;
	endproperty
	a_pwr: assert property (p_pwr) else $error("power done gave no status irq");
	property p_detect;
		$changed(pins_in.card_detect_one) && sm[1] && !gc[1] |-> s_raise;
	endproperty
	a_detect: assert property (p_detect) else $error("detect change gave no status irq");
	property p_batt;
		mem && !gc[1] && ($changed(pins_in.battery_detect_one) && lm[0]
			|| $changed(pins_in.battery_detect_two) && lm[1] || $changed(pins_in.shared_ready_irq) && lm[2])
			|-> s_raise;
	endproperty
	a_batt: assert property (p_batt) else $error("memory card event gave no status irq");
endmodule // csie_events_chk
bind csie_events csie_events_chk #(.NUM_IRQ(NUM_IRQ)) chk_u (.clock_in(clock_in), .sys_rst_in(sys_rst_in),
	.card_type_in(card_type_in), .pins_in(pins_in), .power_done_in(power_done_in), .req_in(req_in),
	.sys_irq_out(sys_irq_out), .status_irq_out(status_irq_out), .func_irq_out(func_irq_out));
`default_nettype wire

// [testbench/csie_card_model.sv]
`timescale 1ns/100ps
`default_nettype none
// socket card, lines pulled inactive while out
module csie_card_model (
	input  wire logic                 clock_in,
	output var csie_pkg::csie_card_t  card_type_out,
	output var csie_pkg::csie_pins_t  pins_out
);
	// empty socket at start
	initial begin
		card_type_out = csie_pkg::CSIE_CARD_NONE;
		pins_out = '0;
	end
	// seating closes both detect contacts
	task automatic insert(input csie_pkg::csie_card_t t);
		@(posedge clock_in);
		card_type_out <= t;
		pins_out <= 5'h03;
	endtask
	// card out for a while, all lines inactive
	task automatic remove();
		@(posedge clock_in);
		card_type_out <= csie_pkg::CSIE_CARD_NONE;
		pins_out <= 5'h00;
		repeat (8) @(posedge clock_in);
	endtask
	// card drives selected terminals
	task automatic set_pin(input logic [4:0] m, input logic v);
		@(posedge clock_in);
		pins_out <= v ? pins_out | m : pins_out & ~m;
	endtask
endmodule // csie_card_model
`default_nettype wire

// [testbench/tb.sv]
`timescale 1ns/100ps
`default_nettype none
module tb;
	localparam csie_pkg::csie_space_t lg = csie_pkg::CSIE_SPACE_LEGACY;
	localparam csie_pkg::csie_space_t cf = csie_pkg::CSIE_SPACE_CONFIG;
	localparam csie_pkg::csie_space_t so = csie_pkg::CSIE_SPACE_SOCKET;
	logic                 clock_in;
	logic                 sys_rst_in;
	logic                 pwr;
	csie_pkg::csie_req_t  req;
	csie_pkg::csie_card_t ctype;
	csie_pkg::csie_pins_t pins;
	logic [31:0]          rdata;
	logic [3:0]           irq;
	logic                 st_irq;
	logic                 fn_irq;
	int                   n_fail;
	int                   n_checks;
	int                   cnt;
	// clock
	initial begin
		clock_in = 1'b0;
		forever #2 clock_in = ~clock_in;
	end
	csie_card_model card_u (.clock_in(clock_in), .card_type_out(ctype), .pins_out(pins));
	csie_events #(.NUM_IRQ(4)) dut_u (.clock_in(clock_in), .sys_rst_in(sys_rst_in), .card_type_in(ctype),
		.pins_in(pins), .power_done_in(pwr), .req_in(req), .rdata_out(rdata), .sys_irq_out(irq),
		.status_irq_out(st_irq), .func_irq_out(fn_irq));
	// compare and count
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		n_checks++;
		if (g !== e) begin
			n_fail++;
			$display("ERROR t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	// one register access, write or read
	task automatic acc(input logic w, input csie_pkg::csie_space_t s, input logic [7:0] a, input logic [31:0] d);
		@(posedge clock_in);
		req <= {w, ~w, s, a, d};
		@(posedge clock_in);
		req <= '0;
		#1;
	endtask
	task automatic rd(input csie_pkg::csie_space_t s, input logic [7:0] a, input logic [31:0] e);
		acc(1'b0, s, a, 32'h0);
		chk(rdata, e);
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clock_in);
		#1;
	endtask
	// power-up finished strobe
	task automatic pulse();
		@(posedge clock_in);
		pwr <= 1'b1;
		@(posedge clock_in);
		pwr <= 1'b0;
	endtask
	task automatic finish_test();
		$display("checks %0d fails %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	// hang guard
	initial begin
		#20000;
		n_fail++;
		finish_test();
	end
	// test sequence
	initial begin
		n_fail = 0;
		n_checks = 0;
		pwr = 1'b0;
		req = '0;
		sys_rst_in = 1'b1;
		repeat (5) @(posedge clock_in);
		sys_rst_in <= 1'b0;
		rd(lg, 8'h04, 32'h0);
		rd(lg, 8'h1E, 32'h0);
		rd(cf, 8'hC0, 32'h10);
		rd(lg, 8'h33, 32'h0);
		acc(1'b1, cf, 8'h91, 32'hFF);
		rd(cf, 8'h91, 32'h0);
		$display("test reset done");
		card_u.insert(csie_pkg::CSIE_CARD_MEM);
		cyc(8);
		chk(32'(st_irq), 32'h0);
		acc(1'b1, lg, 8'h05, 32'h0F);
		card_u.set_pin(5'h1C, 1'b1);
		cyc(10);
		chk(32'(st_irq), 32'h1);
		chk(32'(fn_irq), 32'h0);
		rd(lg, 8'h04, 32'h07);
		rd(lg, 8'h04, 32'h00);
		cyc(2);
		chk(32'(st_irq), 32'h0);
		pulse();
		cyc(3);
		rd(lg, 8'h04, 32'h08);
		rd(so, 8'h00, 32'h06);
		acc(1'b1, so, 8'h00, 32'h02);
		rd(so, 8'h00, 32'h04);
		$display("test memory card done");
		card_u.remove();
		card_u.insert(csie_pkg::CSIE_CARD_IO);
		cyc(8);
		acc(1'b1, lg, 8'h1E, 32'h04);
		acc(1'b1, so, 8'h00, 32'h06);
		card_u.set_pin(5'h10, 1'b1);
		cyc(8);
		rd(lg, 8'h04, 32'h01);
		rd(lg, 8'h04, 32'h01);
		acc(1'b1, lg, 8'h04, 32'h00);
		rd(lg, 8'h04, 32'h01);
		acc(1'b1, lg, 8'h04, 32'h01);
		rd(lg, 8'h04, 32'h00);
		card_u.set_pin(5'h04, 1'b1);
		cyc(8);
		chk(32'(fn_irq), 32'h1);
		rd(cf, 8'h91, 32'h01);
		chk(32'(irq), 32'h2);
		card_u.set_pin(5'h04, 1'b0);
		acc(1'b1, lg, 8'h1E, 32'h00);
		$display("test io card done");
		card_u.remove();
		card_u.insert(csie_pkg::CSIE_CARD_CB);
		cyc(8);
		acc(1'b1, so, 8'h04, 32'h0F);
		acc(1'b1, so, 8'h00, 32'h0F);
		card_u.set_pin(5'h10, 1'b1);
		pulse();
		cyc(8);
		rd(so, 8'h00, 32'h09);
		chk(32'(st_irq), 32'h1);
		acc(1'b1, cf, 8'hC0, 32'h23);
		card_u.set_pin(5'h04, 1'b1);
		cyc(8);
		chk(32'(irq), 32'hC);
		acc(1'b1, so, 8'h00, 32'h09);
		cyc(2);
		chk(32'(irq), 32'h4);
		card_u.set_pin(5'h14, 1'b0);
		$display("test cardbus done");
		card_u.remove();
		card_u.insert(csie_pkg::CSIE_CARD_MEM);
		cyc(8);
		acc(1'b1, so, 8'h00, 32'h0F);
		acc(1'b1, lg, 8'h1E, 32'h02);
		pulse();
		cnt = 0;
		repeat (12) begin
			@(posedge clock_in);
			#1;
			cnt += int'(st_irq === 1'b1);
		end
		chk(cnt, 32'h1);
		$display("test edge mode done");
		finish_test();
	end
endmodule // tb
`default_nettype wire
